// ==== jipe_pkg.sv ====
/*
  Shared constants for the test-port pin enable block: register offsets,
  field positions, reset values and the serial command codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package jipe_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ    = 4'h2;
  localparam logic [3:0] REG_MASK   = 4'h3;
  // control register fields
  localparam int CTRL_CPU_EN   = 0;
  localparam int CTRL_PUSHPULL = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // interrupt event bits
  localparam int EV_ON   = 0;
  localparam int EV_EXT  = 1;
  localparam int EV_ERR  = 2;
  localparam int EV_DONE = 3;
  localparam int EV_W    = 4;
  // serial command codes, shifted in lsb first on the data-in line
  localparam int CMD_W = 4;
  localparam logic [3:0] CMD_ENABLE     = 4'h1;
  localparam logic [3:0] CMD_ENABLE_EXT = 4'h3;
  localparam logic [3:0] CMD_DISABLE    = 4'hF;
  localparam logic [3:0] CMD_BYPASS     = 4'hE;
endpackage

// ==== jipe_shift_if.sv ====
/*
  Bundle between the serial command shifter and the top block.
  Assumes one core clock shared by both ends.
*/
`timescale 1ns/1ps
interface jipe_shift_if;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       mode_sel;
  logic       data_in;
  logic       cmd_valid;
  logic [3:0] cmd_code;
  modport shifter (input sclk_rise, input sclk_fall, input mode_sel,
                   input data_in, output cmd_valid, output cmd_code);
  modport top     (output sclk_rise, output sclk_fall, output mode_sel,
                   output data_in, input cmd_valid, input cmd_code);
endinterface

// ==== jipe_shifter.sv ====
/*
  Serial command shifter: collects data-in bits on test clock rises while
  mode select is low, and offers a command on a test clock rise with mode select high.
  Assumes edge pulses come from synchronised pins in the core domain.
*/
`timescale 1ns/1ps
module jipe_shifter (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        active,
  jipe_shift_if.shifter    sif
);
  logic [3:0] sh_q;
  logic [2:0] cnt_q;
  logic       vld_q;

  // shift bits in; a frame of exactly four bits makes a command
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sh_q  <= 4'h0;
      cnt_q <= 3'h0;
      vld_q <= 1'b0;
    end else begin
      vld_q <= 1'b0;
      if (!active) begin
        cnt_q <= 3'h0;
      end else if (sif.sclk_rise) begin
        if (sif.mode_sel) begin
          vld_q <= (cnt_q == 3'h4);
          cnt_q <= 3'h0;
        end else begin
          sh_q  <= {sif.data_in, sh_q[3:1]};
          cnt_q <= (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
        end
      end
    end
  end

  assign sif.cmd_valid = vld_q;
  assign sif.cmd_code  = sh_q;
endmodule

// ==== jipe_top.sv ====
/*
  Test-port pin enable: decides when port C lines carry the programming
  test port, maps the signals and drives the status and error extensions.
  Assumes pins arrive asynchronous to core_clk; flash status from the core.
*/
`timescale 1ns/1ps

// What this block does
// [RULE_01] test-port enable is OR of pin config, logic equation, cpu bit
// [RULE_02] dedicated pin configuration keeps lines in test function always
// [RULE_03] shared mode: one logic input returns lines to programming use
// [RULE_04] board should wire that input to the cable enable output
// [RULE_05] cpu enable bit clears on any reset, dropping that source
// [RULE_06] mode line0, clock line1, data in line5, data out line6
// [RULE_07] status on line3, error on line4 when extensions enabled
// [RULE_08] status and error enabled together by one serial command
// [RULE_09] error output driven low when erase or program fails
// [RULE_10] status output high in read mode, low while busy
// [RULE_11] extensions open-drain by default, push-pull selectable
// [RULE_12] blank part: configuration register bits all zero
// [RULE_13] blank part: basic test lines enabled without configuration
// [RULE_14] disabled test port leaves the four lines as general I/O
// [RULE_15] data out drives only after enabling command received
// [RULE_16] no boundary scan; remain in bypass during chain scans
// [RULE_17] lines 3 and 4 stay general I/O until extensions enabled
module jipe_top (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       pin_cfg_dedicated,
  input  wire logic       cfg_blank,
  input  wire logic       cable_program_enable,
  input  wire logic       flash_busy,
  input  wire logic       flash_fail,
  input  wire logic [7:0] gpio_out,
  input  wire logic [7:0] gpio_oe,
  input  wire logic [7:0] port_c_in,
  output logic      [7:0] port_c_out,
  output logic      [7:0] port_c_oe,
  output logic      [7:0] gpio_in,
  output logic            test_port_on,
  output logic            in_system_programming,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq
);
  logic [7:0] pin_s1_q, pin_s2_q;
  logic       en_s1_q, en_s2_q;
  logic       sclk_d1_q;
  logic [7:0] ctrl_q;
  logic [3:0] ev_q, mask_q;
  logic       on_q, ext_q, ext_prev_q, on_prev_q, busy_prev_q, err_q;
  logic       on_d;
  jipe_shift_if sif ();

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; nothing reads the first stage but the second
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      en_s1_q  <= 1'b0;
      en_s2_q  <= 1'b0;
      sclk_d1_q <= 1'b0;
    end else begin
      pin_s1_q <= port_c_in;
      pin_s2_q <= pin_s1_q;
      en_s1_q  <= cable_program_enable;
      en_s2_q  <= en_s1_q;
      sclk_d1_q <= pin_s2_q[1];
    end
  end

  // [RULE_06] fixed line mapping
  assign sif.mode_sel  = pin_s2_q[0];
  assign sif.data_in   = pin_s2_q[5];
  assign sif.sclk_rise = pin_s2_q[1] & ~sclk_d1_q;
  assign sif.sclk_fall = ~pin_s2_q[1] & sclk_d1_q;

  jipe_shifter u_shift (
    .core_clk (core_clk),
    .rstn     (rstn),
    .active   (on_q),
    .sif      (sif)
  );

  //////////////////////////////////////////////////////////////////////////
  // [RULE_01] enable sources ORed
  // [RULE_02] [RULE_03] [RULE_13] pin, equation, blank part hold it on
  always_comb begin
    on_d = pin_cfg_dedicated | en_s2_q | cfg_blank
         | ctrl_q[jipe_pkg::CTRL_CPU_EN];
  end

  // [RULE_15] [RULE_08] [RULE_16] command decode; bypass leaves state alone
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      on_q  <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      on_q <= on_d;
      if (!on_d) begin
        ext_q <= 1'b0;
      end else if (sif.cmd_valid) begin
        unique case (sif.cmd_code)
          jipe_pkg::CMD_ENABLE:     ext_q <= 1'b0;
          jipe_pkg::CMD_ENABLE_EXT: ext_q <= 1'b1;
          jipe_pkg::CMD_DISABLE:    ext_q <= 1'b0;
          default:                  ext_q <= ext_q;
        endcase
      end
    end
  end

  // data-out drive armed by an enabling command; dropped on disable
  logic drv_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drv_q <= 1'b0;
    end else if (!on_d) begin
      drv_q <= 1'b0;
    end else if (sif.cmd_valid) begin
      if (sif.cmd_code == jipe_pkg::CMD_ENABLE ||
          sif.cmd_code == jipe_pkg::CMD_ENABLE_EXT) begin
        drv_q <= 1'b1;
      end else if (sif.cmd_code == jipe_pkg::CMD_DISABLE) begin
        drv_q <= 1'b0;
      end
    end
  end

  // [RULE_09] error latched low until a new busy cycle starts
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      err_q       <= 1'b0;
      busy_prev_q <= 1'b0;
    end else begin
      busy_prev_q <= flash_busy;
      if (flash_fail) begin
        err_q <= 1'b1;
      end else if (flash_busy & ~busy_prev_q) begin
        err_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drive; outputs all registered
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      port_c_out <= 8'h00;
      port_c_oe  <= 8'h00;
      gpio_in    <= 8'h00;
      test_port_on <= 1'b0;
      in_system_programming <= 1'b0;
    end else begin
      test_port_on <= on_q;
      in_system_programming <= on_q & drv_q;
      gpio_in    <= pin_s2_q;
      port_c_out <= gpio_out;
      port_c_oe  <= gpio_oe;
      // [RULE_14] off: lines follow general I/O
      if (on_q) begin
        // [RULE_15] mode, clock and data in always input; data out input until command
        port_c_oe[0]  <= 1'b0;
        port_c_oe[1]  <= 1'b0;
        port_c_oe[5]  <= 1'b0;
        port_c_out[0] <= 1'b0;
        port_c_out[1] <= 1'b0;
        port_c_out[5] <= 1'b0;
        // bypass: no scan register, data out echoes data in
        port_c_out[6] <= pin_s2_q[5];
        port_c_oe[6]  <= drv_q;
      end
      // [RULE_17] [RULE_07] extension lines only when enabled
      if (on_q & ext_q) begin
        // [RULE_10] [RULE_11] status high when idle, low busy
        port_c_out[3] <= ~flash_busy;
        port_c_oe[3]  <= ctrl_q[jipe_pkg::CTRL_PUSHPULL] | flash_busy;
        port_c_out[4] <= ~err_q;
        port_c_oe[4]  <= ctrl_q[jipe_pkg::CTRL_PUSHPULL] | err_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // [RULE_05] [RULE_12] control register clears on any reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= jipe_pkg::CTRL_RESET;
      mask_q <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == jipe_pkg::REG_CTRL) begin
        ctrl_q <= reg_wdata;
      end
      if (reg_addr == jipe_pkg::REG_MASK) begin
        mask_q <= reg_wdata[3:0];
      end
    end
  end

  // sticky events; a new event wins over the read clear
  logic [3:0] ev_set;
  always_comb begin
    ev_set = 4'h0;
    ev_set[jipe_pkg::EV_ON]   = on_q & ~on_prev_q;
    ev_set[jipe_pkg::EV_EXT]  = ext_q & ~ext_prev_q;
    ev_set[jipe_pkg::EV_ERR]  = flash_fail;
    ev_set[jipe_pkg::EV_DONE] = ~flash_busy & busy_prev_q;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ev_q       <= 4'h0;
      on_prev_q  <= 1'b0;
      ext_prev_q <= 1'b0;
      irq        <= 1'b0;
    end else begin
      on_prev_q  <= on_q;
      ext_prev_q <= ext_q;
      if (reg_rd && reg_addr == jipe_pkg::REG_IRQ) begin
        ev_q <= ev_set;
      end else begin
        ev_q <= ev_q | ev_set;
      end
      irq <= |(ev_q & mask_q);
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        jipe_pkg::REG_CTRL:   reg_rdata <= ctrl_q;
        jipe_pkg::REG_STATUS: reg_rdata <= {3'h0, err_q, flash_busy,
                                            drv_q, ext_q, on_q};
        jipe_pkg::REG_IRQ:    reg_rdata <= {4'h0, ev_q};
        jipe_pkg::REG_MASK:   reg_rdata <= {4'h0, mask_q};
        default:              reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_on_follows: assert property (@(posedge core_clk) disable iff (!rstn)
    on_d |=> on_q) else $error("enable not taken"); // [RULE_01]
  chk_cpu_source: assert property (@(posedge core_clk) disable iff (!rstn)
    ctrl_q[0] |=> ##1 test_port_on) else $error("cpu bit ignored"); // [RULE_05]
  chk_lines_gpio: assert property (@(posedge core_clk) disable iff (!rstn)
    !on_q |=> port_c_oe[0] == $past(gpio_oe[0])) else $error("gpio lost"); // [RULE_14]
  chk_tdo_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    on_q && !drv_q |=> !port_c_oe[6]) else $error("data out early"); // [RULE_15]
  chk_ext_gpio: assert property (@(posedge core_clk) disable iff (!rstn)
    !ext_q |=> port_c_oe[3] == $past(gpio_oe[3])) else $error("ext early"); // [RULE_17]
  chk_stat_busy: assert property (@(posedge core_clk) disable iff (!rstn)
    on_q && ext_q && flash_busy |=> !port_c_out[3] && port_c_oe[3])
    else $error("status not low"); // [RULE_10]
  chk_err_low: assert property (@(posedge core_clk) disable iff (!rstn)
    on_q && ext_q && on_d && flash_fail |=> ##1 !port_c_out[4] && port_c_oe[4])
    else $error("error not low"); // [RULE_09]
  chk_open_drain: assert property (@(posedge core_clk) disable iff (!rstn)
    on_q && ext_q && !ctrl_q[1] && !flash_busy |=> !port_c_oe[3])
    else $error("status drives high"); // [RULE_11]
  chk_ext_cmd: assert property (@(posedge core_clk) disable iff (!rstn)
    on_d && sif.cmd_valid && sif.cmd_code == jipe_pkg::CMD_ENABLE_EXT
    |=> ext_q && drv_q) else $error("ext command lost"); // [RULE_08]
  cov_on: cover property (@(posedge core_clk) $rose(test_port_on));
  cov_ext: cover property (@(posedge core_clk) $rose(ext_q));
  cov_fail: cover property (@(posedge core_clk) ext_q && flash_fail);
endmodule

// ==== jipe_cable_model.sv ====
/*
  Behavioural programming cable on the far side of the test port: drives
  mode select, test clock, data in and its own enable output.
  Assumes the bench resolves pin levels with pull-ups on released lines.
*/
`timescale 1ns/1ps
module jipe_cable_model (
  output logic mode_sel,
  output logic test_clk,
  output logic data_in,
  output logic cable_en
);
  ////////////////////////////////////////////////////////////////////////
  // idle: mode high, test clock stands still between frames
  initial begin
    mode_sel = 1'b1;
    test_clk = 1'b0;
    data_in  = 1'b1;
    cable_en = 1'b0;
  end

  // cable enable wired to the return input
  task automatic set_en(input logic v);
    cable_en = v;
  endtask

  // four bits lsb first, then one clock with mode high
  task automatic send_cmd(input logic [3:0] code);
    for (int i = 0; i < 5; i++) begin
      mode_sel = (i == 4);
      data_in  = (i == 4) ? ~data_in : code[i]; // no stale level on close
      #62.5 test_clk = 1'b1;
      #62.5 test_clk = 1'b0;
    end
  endtask
endmodule

// ==== tb.sv ====
/*
  Self-checking bench for the test-port pin enable block: register tasks,
  a cable model on the link lines and pin levels resolved with pull-ups.
  Assumes a 100 MHz core clock and the package register map.
*/
`timescale 1ns/1ps
module tb;
  logic       core_clk, rstn, pin_cfg_dedicated, cfg_blank;
  logic       flash_busy, flash_fail, reg_wr, reg_rd, irq, irq_a;
  logic       test_port_on, in_system_programming, tms, tck, tdi, cen;
  logic [7:0] gpio_out, gpio_oe, port_c_out, port_c_oe, gpio_in;
  logic [7:0] pins, cab, reg_wdata, reg_rdata, rd_q;
  logic [3:0] reg_addr;
  int         miscompares = 0;
  int         check_count = 0;
  int         cycles      = 0;

  ////////////////////////////////////////////////////////////////////////
  // wired pin level: device drive, else cable, else pull-up
  assign cab  = {2'b11, tdi, 3'b111, tck, tms};
  assign pins = (port_c_oe & port_c_out) | (~port_c_oe & cab);

  jipe_top i_jipe_top (.core_clk, .rstn, .pin_cfg_dedicated, .cfg_blank,
    .cable_program_enable(cen), .flash_busy, .flash_fail, .gpio_out,
    .gpio_oe, .port_c_in(pins), .port_c_out, .port_c_oe, .gpio_in,
    .test_port_on, .in_system_programming, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq);
  jipe_cable_model i_jipe_cable_model (.mode_sel(tms), .test_clk(tck),
    .data_in(tdi), .cable_en(cen));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, far above the expected five hundred or so cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask

  // drive one of the four enable sources
  task automatic src(input int s, input logic v);
    case (s)
      0: pin_cfg_dedicated <= v;
      1: cfg_blank <= v;
      2: i_jipe_cable_model.set_en(v);
      default: wr(jipe_pkg::REG_CTRL, {7'h00, v});
    endcase
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0; pin_cfg_dedicated = 1'b0; cfg_blank = 1'b0;
    flash_busy = 1'b0; flash_fail = 1'b0; gpio_out = 8'hA5;
    gpio_oe = 8'hFF; reg_addr = 4'h0; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    settle;
    chk(test_port_on, 1'b0);
    chk(port_c_oe, 8'hFF);
    chk(gpio_in, 8'hA5);
    rd(jipe_pkg::REG_CTRL);
    chk(rd_q, jipe_pkg::CTRL_RESET);
    rd(4'h7);
    chk(rd_q, 8'h00);
    // each source alone turns the port on; lines 3 and 4 stay general
    for (int s = 0; s < 4; s++) begin
      src(s, 1'b1);
      settle;
      chk(test_port_on, 1'b1);
      chk(port_c_oe & 8'h7B, 8'h18);
      src(s, 1'b0);
      settle;
      chk(test_port_on, 1'b0);
    end
    // reset in mid-run drops the cpu enable bit
    wr(jipe_pkg::REG_CTRL, 8'h01);
    settle;
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    settle;
    chk(test_port_on, 1'b0);
    // blank part enables the port; bypass code changes nothing
    cfg_blank <= 1'b1;
    settle;
    chk(test_port_on, 1'b1);
    rd(jipe_pkg::REG_IRQ);
    i_jipe_cable_model.send_cmd(jipe_pkg::CMD_BYPASS);
    settle;
    chk(in_system_programming, 1'b0);
    chk(port_c_oe & 8'h63, 8'h00);
    i_jipe_cable_model.send_cmd(jipe_pkg::CMD_ENABLE);
    settle;
    chk(port_c_oe & 8'h7B, 8'h58);
    chk(in_system_programming, 1'b1);
    i_jipe_cable_model.send_cmd(jipe_pkg::CMD_ENABLE_EXT);
    settle;
    rd(jipe_pkg::REG_STATUS);
    chk(rd_q & 8'h03, 8'h03);
    chk(port_c_oe & 8'h18, 8'h00);
    chk(pins & 8'h18, 8'h18);
    flash_busy <= 1'b1;
    settle;
    chk(pins & 8'h18, 8'h10);
    flash_busy <= 1'b0;
    @(posedge core_clk);
    flash_fail <= 1'b1;
    @(posedge core_clk);
    flash_fail <= 1'b0;
    settle;
    chk(pins & 8'h18, 8'h08);
    wr(jipe_pkg::REG_CTRL, 8'h02);
    settle;
    chk(port_c_oe & port_c_out & 8'h08, 8'h08);
    // mask flips the level output while events are pending
    wr(jipe_pkg::REG_MASK, 8'h00);
    settle;
    irq_a = irq;
    wr(jipe_pkg::REG_MASK, 8'hFF);
    settle;
    chk(irq ^ irq_a, 1'b1);
    rd(jipe_pkg::REG_IRQ);
    chk(rd_q & 8'h0E, 8'h0E);
    rd(jipe_pkg::REG_IRQ);
    chk(rd_q, 8'h00);
    settle;
    chk(irq, 1'b0);
    i_jipe_cable_model.send_cmd(jipe_pkg::CMD_DISABLE);
    settle;
    chk(in_system_programming, 1'b0);
    chk(port_c_oe & 8'h18, 8'h18);
    complete_run();
  end
endmodule
